// [hw/tsa_pkg.sv]
// Package with the constants and types of the temperature sensor alert core.
package tsa_pkg;

  // ----------------------------------------
  // Register pointer values
  // ----------------------------------------
  localparam logic [1:0] TSA_PTR_TEMP = 2'h0;
  localparam logic [1:0] TSA_PTR_CFG = 2'h1;
  localparam logic [1:0] TSA_PTR_LOW = 2'h2;
  localparam logic [1:0] TSA_PTR_HIGH = 2'h3;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [15:0] TSA_TEMP_RST = 16'h0000;
  localparam logic [15:0] TSA_LOW_RST = 16'h2580;
  localparam logic [15:0] TSA_HIGH_RST = 16'h2800;
  localparam logic [15:0] TSA_LIMIT_MASK = 16'hFFF0;
  localparam logic [1:0] TSA_CR_RST = 2'h2;
  localparam logic TSA_CFG_B14 = 1'h1;

  // ----------------------------------------
  // Configuration field positions
  // ----------------------------------------
  localparam int TSA_CFG_AL = 5;
  localparam int TSA_CFG_CR = 6;
  localparam int TSA_CFG_SM = 8;
  localparam int TSA_CFG_IM = 9;
  localparam int TSA_CFG_POL = 10;
  localparam int TSA_CFG_CF = 11;
  localparam int TSA_CFG_RES14 = 14;
  localparam int TSA_CFG_SS = 15;

  // ----------------------------------------
  // Bus constants
  // ----------------------------------------
  localparam logic [2:0] TSA_ADDR_HI = 3'h5;
  localparam logic [6:0] TSA_GCALL_ADDR = 7'h00;
  localparam logic [7:0] TSA_GRESET_BYTE = 8'h06;
  localparam logic [3:0] TSA_BITS_BYTE = 4'h8;
  localparam logic [1:0] TSA_STRAP2_SCL = 2'h0;
  localparam logic [1:0] TSA_STRAP2_PULLUP = 2'h2;
  localparam int TSA_SYNC_W = 6;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {TSA_IDLE, TSA_ADDR, TSA_ACK, TSA_WR, TSA_TX, TSA_MACK} tsa_i2c_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic [1:0] strap_first;
    logic [1:0] strap_second;
  } tsa_pins_t;

  typedef struct packed {
    logic [1:0] rate;
    logic sleep;
    logic irq_mode;
    logic level;
    logic [1:0] faults;
    logic single_shot;
  } tsa_cfg_t;

endpackage

// [hw/tsa_sync.sv]
// Two-stage synchroniser for the bus and strap pins.
`timescale 1ns/100ps
`default_nettype none
module tsa_sync
(
  input wire logic clk,
  input wire logic rstn,
  input wire tsa_pkg::tsa_pins_t pins_in,
  output var tsa_pkg::tsa_pins_t pins_out
);
  import tsa_pkg::*;

  typedef struct packed {
    tsa_pins_t first;
    tsa_pins_t second;
  } tsa_sync_st_t;

  tsa_sync_st_t st;
  tsa_sync_st_t next_st;

  // ----------------------------------------
  // Two flip-flops, the first read only by the second
  // ----------------------------------------
  always_comb
  begin
    next_st.first = pins_in;
    next_st.second = st.first;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // Straps keep flowing in reset so that they are settled when it ends.
      st <= next_st;
      st.first.scl <= 1'b1;
      st.first.sda <= 1'b1;
      st.second.scl <= 1'b1;
      st.second.sda <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pins_out = st.second;

endmodule
`default_nettype wire

// [hw/tsa_alert.sv]
// Alert engine with comparator and interrupt modes and fault counting.
`timescale 1ns/100ps
`default_nettype none
module tsa_alert
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic conv_valid,
  input wire logic [15:0] temp,
  input wire logic [15:0] high_limit,
  input wire logic [15:0] low_limit,
  input wire tsa_pkg::tsa_cfg_t cfg,
  input wire logic clear,
  input wire logic alert_en,
  output logic alert_bit,
  output logic alert_oe_n
);
  import tsa_pkg::*;

  typedef struct packed {
    logic active;
    logic phase_low;
    logic [1:0] cnt;
    logic im_d;
    logic level;
    logic oe_n;
  } tsa_alert_st_t;

  tsa_alert_st_t st;
  tsa_alert_st_t next_st;
  logic hi_hit;
  logic lo_hit;
  logic cond;
  logic waiting;

  // ----------------------------------------
  // Threshold compare and state update
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    hi_hit = $signed(temp) >= $signed(high_limit);
    lo_hit = $signed(temp) <= $signed(low_limit);
    cond = cfg.irq_mode ? (st.phase_low ? lo_hit : hi_hit) : (st.active ? lo_hit : hi_hit);
    waiting = cfg.irq_mode ? !st.active : 1'b1;
    next_st.im_d = cfg.irq_mode;
    if (cfg.irq_mode != st.im_d)
    begin
      next_st.active = 1'b0;
      next_st.phase_low = 1'b0;
      next_st.cnt = 2'h0;
    end
    else
    begin
      if (cfg.irq_mode && clear)
      begin
        next_st.active = 1'b0; // see R3 R4
      end
      if (conv_valid && waiting)
      begin
        if (!cond)
        begin
          next_st.cnt = 2'h0; // see R25
        end
        else if (st.cnt == cfg.faults) // see R22
        begin
          next_st.cnt = 2'h0;
          if (cfg.irq_mode)
          begin
            next_st.active = 1'b1; // see R2 R5
            next_st.phase_low = !st.phase_low; // see R6
          end
          else
          begin
            next_st.active = !st.active; // see R1
          end
        end
        else
        begin
          next_st.cnt = st.cnt + 2'h1;
        end
      end
    end
    next_st.level = cfg.level ? next_st.active : !next_st.active; // see R23
    next_st.oe_n = alert_en ? next_st.level : 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st <= '{active: 1'b0, phase_low: 1'b0, cnt: 2'h0, im_d: 1'b0, level: 1'b1, oe_n: 1'b1};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign alert_bit = st.level;
  assign alert_oe_n = st.oe_n;

endmodule
`default_nettype wire

// [hw/tsa_top.sv]
// Temperature sensor digital core: bus slave, registers and alert pin.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: Comparator mode: alert follows N-fault threshold crossings.
// R2: Interrupt mode: N faults above high assert.
// R3: Interrupt alert held until any register read.
// R4: Entering sleep clears interrupt alert.
// R5: After clear, N faults below low reassert.
// R6: Phases alternate; general reset returns comparator mode.
// R7: Limits reset to 0x2580 and 0x2800.
// R8: Limit bits 3..0 read zero, ignore writes.
// R9: Limits two's complement, upper byte first.
// R10: Temperature read as upper then lower byte.
// R11: Temperature is signed, 1/128 degree steps.
// R12: Temperature reads zero until first conversion.
// R13: Master opens each transfer with START.
// R14: Address then direction bit, decoded here.
// R15: Sample on SCL rise, acknowledge ninth pulse.
// R16: SDA change with SCL high is START/STOP.
// R17: Master closes each transfer with STOP.
// R18: Bytes shift most significant bit first.
// R19: Fast and high-speed SCL rates supported.
// R20: Slave address comes from two strap pins.
// R21: Straps connected; alert needs pulled-up second strap.
// R22: Fault count field selects one to four.
// R23: Level select sets alert asserted polarity.
// R24: Pointer low bits select target register.
// R25: Failing conversion restarts the fault count.
module tsa_top
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] addr_strap_first,
  input wire logic [1:0] addr_strap_second,
  output logic alert_out,
  output logic alert_oe_n,
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  output logic [1:0] conv_rate,
  output logic sleep_sel,
  output logic single_shot
);
  import tsa_pkg::*;

  typedef struct packed {
    tsa_i2c_state_t fsm;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic gc;
    logic gc_seen;
    logic ptr_next;
    logic lsb_next;
    logic nack;
    logic [7:0] hold;
    logic [1:0] ptr;
    logic [15:0] txw;
    logic [15:0] temp_value;
    logic [15:0] low_limit;
    logic [15:0] high_limit;
    tsa_cfg_t cfg;
    logic [6:0] addr;
    logic alert_en;
    logic strap_ok;
    logic scl_d;
    logic sda_d;
    logic sda_oe_n;
    logic drive;
    logic read_pulse;
    logic sleep_pulse;
  } tsa_st_t;

  tsa_st_t st;
  tsa_st_t next_st;
  tsa_pins_t pins;
  logic alert_bit;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] bytev;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [15:0] cfg_word(input tsa_cfg_t c, input logic al);
    logic [15:0] w;
    w = 16'h0000;
    w[TSA_CFG_AL] = al;
    w[TSA_CFG_CR +: 2] = c.rate;
    w[TSA_CFG_SM] = c.sleep;
    w[TSA_CFG_IM] = c.irq_mode;
    w[TSA_CFG_POL] = c.level;
    w[TSA_CFG_CF +: 2] = c.faults;
    w[TSA_CFG_RES14] = TSA_CFG_B14;
    w[TSA_CFG_SS] = c.single_shot;
    return w;
  endfunction

  function automatic logic [15:0] reg_read(input tsa_st_t s, input logic al);
    logic [15:0] w;
    w = s.temp_value;
    case (s.ptr) // see R24
      TSA_PTR_CFG: w = cfg_word(s.cfg, al);
      TSA_PTR_LOW: w = s.low_limit & TSA_LIMIT_MASK; // see R8
      TSA_PTR_HIGH: w = s.high_limit & TSA_LIMIT_MASK; // see R8
      default: w = s.temp_value;
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  tsa_sync u_sync
  (
    .clk(clk),
    .rstn(rstn),
    .pins_in('{scl: scl_in, sda: sda_in, strap_first: addr_strap_first, strap_second: addr_strap_second}),
    .pins_out(pins)
  );

  // ----------------------------------------
  // Alert engine
  // ----------------------------------------
  tsa_alert u_alert
  (
    .clk(clk),
    .rstn(rstn),
    .conv_valid(conv_valid),
    .temp(conv_data),
    .high_limit(st.high_limit & TSA_LIMIT_MASK),
    .low_limit(st.low_limit & TSA_LIMIT_MASK),
    .cfg(st.cfg),
    .clear(st.read_pulse | st.sleep_pulse),
    .alert_en(st.alert_en),
    .alert_bit(alert_bit),
    .alert_oe_n(alert_oe_n)
  );

  // ----------------------------------------
  // Bus slave and register file
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.read_pulse = 1'b0;
    next_st.sleep_pulse = 1'b0;
    next_st.scl_d = pins.scl;
    next_st.sda_d = pins.sda;
    scl_rise = pins.scl && !st.scl_d; // see R19
    scl_fall = !pins.scl && st.scl_d;
    start_cond = pins.scl && st.scl_d && st.sda_d && !pins.sda; // see R16
    stop_cond = pins.scl && st.scl_d && !st.sda_d && pins.sda; // see R16
    bytev = st.lsb_next ? st.txw[7:0] : st.txw[15:8];

    if (!st.strap_ok)
    begin
      next_st.strap_ok = 1'b1;
      next_st.addr = {TSA_ADDR_HI, pins.strap_second != TSA_STRAP2_SCL,
                      pins.strap_second == TSA_STRAP2_SCL, pins.strap_first}; // see R20
      next_st.alert_en = pins.strap_second == TSA_STRAP2_PULLUP; // see R21
    end

    if (conv_valid)
    begin
      next_st.temp_value = conv_data; // see R11 R12
      next_st.cfg.single_shot = 1'b0;
    end

    case (st.fsm)
      TSA_ADDR, TSA_WR:
      begin
        if (scl_rise)
        begin
          next_st.shreg = {st.shreg[6:0], pins.sda}; // see R15 R18
          next_st.cnt = st.cnt + 4'h1;
        end
        else if (scl_fall && st.cnt == TSA_BITS_BYTE)
        begin
          next_st.cnt = 4'h0;
          if (st.fsm == TSA_ADDR)
          begin
            if (st.shreg[7:1] == st.addr || st.shreg[7:1] == TSA_GCALL_ADDR)
            begin
              next_st.sda_oe_n = 1'b0; // see R15
              next_st.rw = st.shreg[0]; // see R14
              next_st.gc = st.shreg[7:1] == TSA_GCALL_ADDR && !st.shreg[0];
              next_st.ptr_next = 1'b1;
              next_st.lsb_next = 1'b0;
              next_st.fsm = TSA_ACK;
            end
            else
            begin
              next_st.fsm = TSA_IDLE;
            end
          end
          else if (st.gc && st.gc_seen)
          begin
            next_st.fsm = TSA_IDLE;
          end
          else
          begin
            next_st.sda_oe_n = 1'b0;
            next_st.fsm = TSA_ACK;
            if (st.gc)
            begin
              next_st.gc_seen = 1'b1;
              if (st.shreg == TSA_GRESET_BYTE)
              begin
                next_st.cfg.irq_mode = 1'b0; // see R6
              end
            end
            else if (st.ptr_next)
            begin
              next_st.ptr = st.shreg[1:0]; // see R24
              next_st.ptr_next = 1'b0;
            end
            else if (!st.lsb_next)
            begin
              next_st.hold = st.shreg; // see R9
              next_st.lsb_next = 1'b1;
            end
            else
            begin
              next_st.lsb_next = 1'b0;
              case (st.ptr)
                TSA_PTR_CFG:
                begin
                  next_st.cfg.rate = st.shreg[TSA_CFG_CR +: 2];
                  next_st.cfg.sleep = st.hold[TSA_CFG_SM - 8];
                  next_st.cfg.irq_mode = st.hold[TSA_CFG_IM - 8];
                  next_st.cfg.level = st.hold[TSA_CFG_POL - 8];
                  next_st.cfg.faults = st.hold[TSA_CFG_CF - 8 +: 2]; // see R22
                  next_st.cfg.single_shot = st.hold[TSA_CFG_SS - 8];
                  next_st.sleep_pulse = st.hold[TSA_CFG_SM - 8] && !st.cfg.sleep; // see R4
                end
                TSA_PTR_LOW: next_st.low_limit = {st.hold, st.shreg} & TSA_LIMIT_MASK; // see R8 R9
                TSA_PTR_HIGH: next_st.high_limit = {st.hold, st.shreg} & TSA_LIMIT_MASK; // see R8 R9
                default: next_st.temp_value = st.temp_value;
              endcase
            end
          end
        end
      end
      TSA_ACK:
      begin
        if (scl_fall)
        begin
          if (st.rw)
          begin
            next_st.txw = reg_read(st, alert_bit);
            bytev = next_st.txw[15:8]; // see R10
            next_st.sda_oe_n = bytev[7]; // see R18
            next_st.shreg = {bytev[6:0], 1'b1};
            next_st.cnt = 4'h1;
            next_st.fsm = TSA_TX;
          end
          else
          begin
            next_st.sda_oe_n = 1'b1;
            next_st.cnt = 4'h0;
            next_st.fsm = TSA_WR;
          end
        end
      end
      TSA_TX:
      begin
        if (scl_fall)
        begin
          if (st.cnt == TSA_BITS_BYTE)
          begin
            next_st.sda_oe_n = 1'b1;
            next_st.cnt = 4'h0;
            next_st.fsm = TSA_MACK;
          end
          else
          begin
            next_st.sda_oe_n = st.shreg[7]; // see R16 R18
            next_st.shreg = {st.shreg[6:0], 1'b1};
            next_st.cnt = st.cnt + 4'h1;
          end
        end
      end
      TSA_MACK:
      begin
        if (scl_rise)
        begin
          next_st.nack = pins.sda;
          next_st.read_pulse = 1'b1; // see R3
        end
        else if (scl_fall)
        begin
          if (st.nack)
          begin
            next_st.fsm = TSA_IDLE;
          end
          else
          begin
            bytev = st.lsb_next ? st.txw[15:8] : st.txw[7:0]; // see R10
            next_st.lsb_next = !st.lsb_next;
            next_st.sda_oe_n = bytev[7];
            next_st.shreg = {bytev[6:0], 1'b1};
            next_st.cnt = 4'h1;
            next_st.fsm = TSA_TX;
          end
        end
      end
      default:
      begin
        next_st.fsm = TSA_IDLE;
      end
    endcase

    if (start_cond)
    begin
      next_st.fsm = TSA_ADDR; // see R13
      next_st.cnt = 4'h0;
      next_st.sda_oe_n = 1'b1;
      next_st.gc = 1'b0;
      next_st.gc_seen = 1'b0;
    end
    else if (stop_cond)
    begin
      next_st.fsm = TSA_IDLE; // see R17
      next_st.sda_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.fsm <= TSA_IDLE;
      st.scl_d <= 1'b1;
      st.sda_d <= 1'b1;
      st.sda_oe_n <= 1'b1;
      st.temp_value <= TSA_TEMP_RST; // see R12
      st.low_limit <= TSA_LOW_RST; // see R7
      st.high_limit <= TSA_HIGH_RST; // see R7
      st.cfg.rate <= TSA_CR_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sda_out = st.drive;
  assign sda_oe_n = st.sda_oe_n;
  assign alert_out = st.drive;
  assign conv_rate = st.cfg.rate;
  assign sleep_sel = st.cfg.sleep;
  assign single_shot = st.cfg.single_shot;

endmodule
`default_nettype wire

// [verif/tsa_monitor.sv]
// Concurrent checks on the ports of the sensor core.
`timescale 1ns/100ps
`default_nettype none
module tsa_monitor
  import tsa_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [1:0] addr_strap_first,
  input wire logic [1:0] addr_strap_second,
  input wire logic alert_out,
  input wire logic alert_oe_n,
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  input wire logic [1:0] conv_rate,
  input wire logic sleep_sel,
  input wire logic single_shot
);
  // ----------------------------------------
  // Sequences and assertions
  // ----------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence bus_quiet;
    (scl_in && sda_in)[*8];
  endsequence
  sequence conv_quiet;
    (!conv_valid && scl_in && sda_in)[*8];
  endsequence
  AST_SDA_OUT_ZERO: assert property (sda_out == 1'h0)
    else $error("sda data value not zero");
  AST_ALERT_OUT_ZERO: assert property (alert_out == 1'h0)
    else $error("alert data value not zero");
  AST_RESET_STATE: assert property ($rose(rstn) |-> sda_oe_n && alert_oe_n && !sleep_sel && !single_shot)
    else $error("outputs not at reset state");
  AST_SDA_MOVES_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda driver changed while scl high");
  AST_BIT_STANDS: assert property ($changed(sda_oe_n) |=> $stable(sda_oe_n)[*8])
    else $error("sda driver bit too short");
  AST_ALERT_NEEDS_PULLUP: assert property ((addr_strap_second != TSA_STRAP2_PULLUP)[*8] |-> alert_oe_n)
    else $error("alert driven without pull-up strap");
  AST_ALERT_WAITS_CONV: assert property (conv_quiet |=> $stable(alert_oe_n))
    else $error("alert moved without a conversion");
  AST_CFG_WAITS_BUS: assert property (bus_quiet |=> $stable(sleep_sel) && $stable(conv_rate))
    else $error("config moved with bus idle");
endmodule
bind tsa_top tsa_monitor i_tsa_monitor (.clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_first(addr_strap_first),
  .addr_strap_second(addr_strap_second), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
  .conv_valid(conv_valid), .conv_data(conv_data), .conv_rate(conv_rate), .sleep_sel(sleep_sel),
  .single_shot(single_shot));
`default_nettype wire

// [verif/tsa_master.sv]
// Bus master model driving the two-wire serial bus.
`timescale 1ns/100ps
`default_nettype none
module tsa_master
(
  input wire logic clk,
  input wire logic sda_bus,
  output logic scl,
  output logic sda
);
  // ----------------------------------------
  // Bus conditions and bits
  // ----------------------------------------
  initial
  begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task automatic wait_n(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic start();
    sda = 1'h1;
    wait_n(16);
    scl = 1'h1;
    wait_n(20);
    sda = 1'h0;
    wait_n(20);
    scl = 1'h0;
    wait_n(4);
  endtask
  task automatic stop();
    sda = 1'h0;
    wait_n(16);
    scl = 1'h1;
    wait_n(20);
    sda = 1'h1;
    wait_n(20);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    wait_n(16);
    scl = 1'h1;
    wait_n(20);
    r = sda_bus;
    scl = 1'h0;
    wait_n(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] got, output logic ack_bit);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      got[i] = r;
    end
    bit_io(a, ack_bit);
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the sensor core.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tsa_pkg::*;
  localparam logic [6:0] DEV = 7'h5B;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic conv_valid = 1'h0;
  logic [15:0] conv_data = 16'h0000;
  logic [1:0] strap1 = 2'h0;
  logic [1:0] strap2 = 2'h2;
  logic scl, sda_m, sda_bus, sda_out, sda_oe_n, alert_out, alert_oe_n, sleep_sel, single_shot, ack, alert_level_sel;
  logic [1:0] conv_rate, sec;
  logic [6:0] base;
  logic [7:0] q;
  logic [15:0] v, r;
  int fails = 0;
  int samples_checked = 0;
  int n;
  assign sda_bus = sda_m & (sda_oe_n | sda_out);
  always #2 clk = ~clk;
  tsa_master master (.clk(clk), .sda_bus(sda_bus), .scl(scl), .sda(sda_m));
  tsa_top i_tsa_top (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_strap_first(strap1), .addr_strap_second(strap2), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .conv_valid(conv_valid), .conv_data(conv_data), .conv_rate(conv_rate),
    .sleep_sel(sleep_sel), .single_shot(single_shot));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] cfgv(input logic [1:0] cf, input logic pl, input logic im, input logic sm);
    return {3'h0, cf, pl, im, sm, 8'h80};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic reset_dut(input logic [1:0] s1, input logic [1:0] s2);
    @(negedge clk);
    rstn = 1'h0;
    strap1 = s1;
    strap2 = s2;
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    repeat (8) @(negedge clk);
  endtask
  task automatic probe(input logic [6:0] a, input logic exp);
    master.start();
    master.xfer({a, 1'h0}, 1'h1, q, ack);
    master.stop();
    check("address ack", {15'h0, ack}, {15'h0, exp});
  endtask
  task automatic wr_reg(input logic [1:0] ptr, input logic [15:0] val);
    master.start();
    master.xfer({DEV, 1'h0}, 1'h1, q, ack);
    check("write ack", {15'h0, ack}, 16'h0000);
    master.xfer({6'h0, ptr}, 1'h1, q, ack);
    master.xfer(val[15:8], 1'h1, q, ack);
    master.xfer(val[7:0], 1'h1, q, ack);
    master.stop();
  endtask
  task automatic rd_reg(input logic [1:0] ptr, output logic [15:0] val);
    master.start();
    master.xfer({DEV, 1'h0}, 1'h1, q, ack);
    master.xfer({6'h0, ptr}, 1'h1, q, ack);
    master.start();
    master.xfer({DEV, 1'h1}, 1'h1, q, ack);
    master.xfer(8'hFF, 1'h0, val[15:8], ack);
    master.xfer(8'hFF, 1'h1, val[7:0], ack);
    master.stop();
  endtask
  task automatic convert(input logic [15:0] t, input int k);
    repeat (k)
    begin
      @(negedge clk);
      conv_valid = 1'h1;
      conv_data = t;
      @(negedge clk);
      conv_valid = 1'h0;
      repeat (3) @(negedge clk);
    end
  endtask
  task automatic al(input logic act, input logic pl);
    check("alert", {15'h0, alert_oe_n}, {15'h0, act ? pl : ~pl});
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(53630));
    for (n = 0; n < 4; n++)
    begin
      sec = (n == 1) ? 2'h0 : ((n == 2) ? 2'h1 : 2'h2);
      reset_dut(n[1:0], sec);
      base = (sec == 2'h0) ? 7'h54 : 7'h58;
      probe(base | 7'(n), 1'h0);
      probe((base ^ 7'h0C) | 7'(n), 1'h1);
    end
    $display("test address done");
    rd_reg(TSA_PTR_TEMP, r);
    check("temp reset", r, TSA_TEMP_RST);
    rd_reg(TSA_PTR_LOW, r);
    check("low reset", r, 16'h2580);
    rd_reg(TSA_PTR_HIGH, r);
    check("high reset", r, 16'h2800);
    $display("test reset done");
    for (n = 0; n < 2; n++)
    begin
      v = (n == 0) ? 16'h8000 : 16'($urandom);
      convert(v, 1);
      rd_reg(TSA_PTR_TEMP, r);
      check("temperature", r, v);
    end
    convert(16'hFF80, 1);
    $display("test temperature done");
    for (n = 0; n < 3; n++)
    begin
      v = (n == 0) ? 16'hFFFF : 16'($urandom);
      wr_reg(n[0] ? TSA_PTR_HIGH : TSA_PTR_LOW, v);
      rd_reg(n[0] ? TSA_PTR_HIGH : TSA_PTR_LOW, r);
      check("limit", r, v & 16'hFFF0);
    end
    $display("test limits done");
    wr_reg(TSA_PTR_LOW, 16'h1000);
    wr_reg(TSA_PTR_HIGH, 16'h2000);
    for (n = 0; n < 4; n++)
    begin
      alert_level_sel = n[0];
      wr_reg(TSA_PTR_CFG, cfgv(n[1:0], alert_level_sel, 1'h0, 1'h0));
      convert(16'h2000, n);
      convert(16'h1800, 1);
      convert(16'h2000, n);
      al(1'h0, alert_level_sel);
      convert(16'h2000, 1);
      al(1'h1, alert_level_sel);
      convert(16'h1000, n);
      convert(16'h1800, 1);
      convert(16'hFF80, n);
      al(1'h1, alert_level_sel);
      convert(16'hFF80, 1);
      al(1'h0, alert_level_sel);
    end
    $display("test comparator done");
    wr_reg(TSA_PTR_CFG, cfgv(2'h0, 1'h0, 1'h1, 1'h0));
    convert(16'h2000, 1);
    al(1'h1, 1'h0);
    rd_reg(TSA_PTR_TEMP, r);
    al(1'h0, 1'h0);
    convert(16'h2000, 2);
    al(1'h0, 1'h0);
    convert(16'hFF80, 1);
    al(1'h1, 1'h0);
    rd_reg(TSA_PTR_HIGH, r);
    al(1'h0, 1'h0);
    convert(16'h2000, 1);
    al(1'h1, 1'h0);
    wr_reg(TSA_PTR_CFG, cfgv(2'h0, 1'h0, 1'h1, 1'h1));
    al(1'h0, 1'h0);
    master.start();
    master.xfer(8'h00, 1'h1, q, ack);
    master.xfer(TSA_GRESET_BYTE, 1'h1, q, ack);
    master.stop();
    rd_reg(TSA_PTR_CFG, r);
    check("irq mode", {15'h0, r[TSA_CFG_IM]}, 16'h0000);
    check("config", r, cfgv(2'h0, 1'h0, 1'h0, 1'h1) | 16'h4020);
    check("rate", {14'h0, conv_rate}, {14'h0, TSA_CR_RST});
    check("sleep", {15'h0, sleep_sel}, 16'h0001);
    check("single shot", {15'h0, single_shot}, 16'h0000);
    $display("test interrupt done");
    give_verdict();
  end
endmodule
`default_nettype wire
